// ### core/sram1k_pkg.sv
// Package with pin groups, timing constants and states of the 1K x 1 static memory host controller.
// Functional notes
// - The host spaces successive operations by at least the minimum cycle period of the grade.
// - The host holds the address stable for the address-before-write gap before pulling read/write low.
// - The host keeps the device selected for the select-before-write-end time up to the write pulse end.
// - The host keeps the device selected at least 50 ns after read/write returns high.
// - Entering standby the host drives select high at least 100 ns before the supply drops.
// - Leaving standby the host keeps select high at least 100 ns after the supply is restored.
package srhc_pkg;
  localparam int CLK_PERIOD_NS         = 5;
  localparam int MIN_CYCLE_PERIOD_NS   = 400;
  localparam int ADDR_BEFORE_WRITE_NS  = 100;
  localparam int SELECT_BEFORE_END_NS  = 200;
  localparam int WRITE_RECOVERY_NS     = 50;
  localparam int READ_ACCESS_NS        = 400;
  localparam int STANDBY_LEAD_NS       = 100;
  localparam int STANDBY_TRAIL_NS      = 100;
  localparam int ADDR_WIDTH            = 10;
  localparam int CNT_WIDTH             = 8;
  localparam int SYNC_STAGES           = 3;
  // Least times round up to whole clock cycles.
  localparam int CYC_CYCLES   = (MIN_CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AW_CYCLES    = (ADDR_BEFORE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW_CYCLES    = (SELECT_BEFORE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYCLES    = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYCLES   = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYCLES  = (STANDBY_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRAIL_CYCLES = (STANDBY_TRAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_SETUP  = 7'h02,
    ST_PULSE  = 7'h04,
    ST_RECOV  = 7'h08,
    ST_READ   = 7'h10,
    ST_SPACE  = 7'h20,
    ST_SLEEP  = 7'h40
  } srhc_state_t;

  // Pins toward the memory.
  typedef struct packed {
    logic                  selectN;
    logic                  readWriteN;
    logic [ADDR_WIDTH-1:0] wordAddress;
    logic                  dataIn;
  } srhc_pins_t;

  // User request.
  typedef struct packed {
    logic                  write;
    logic [ADDR_WIDTH-1:0] addr;
    logic                  data;
  } srhc_req_t;
endpackage

// ### core/srhc_sync.sv
// Three-stage input synchroniser that accepts a change when stages two and three agree.
`timescale 1ns/100ps
module srhc_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level
);
  typedef struct packed {
    logic [srhc_pkg::SYNC_STAGES-1:0] stage;
    logic                             level;
  } srhc_sync_t;

  srhc_sync_t s_q;
  srhc_sync_t s_d;

  // Shift the pin in; the first stage is read only by the second.
  always_comb begin
    s_d       = s_q;
    s_d.stage = {s_q.stage[srhc_pkg::SYNC_STAGES-2:0], pinIn};
    if (s_q.stage[1] == s_q.stage[2]) begin
      s_d.level = s_q.stage[2];
    end
  end

  // Register the state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;
endmodule

// ### core/srhc_host.sv
// Host controller that runs timed read and write cycles on a 1K x 1 static memory.
`timescale 1ns/100ps
module srhc_host (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              reqValid,
  output logic                                   reqReady,
  input  wire srhc_pkg::srhc_req_t               req,
  output logic                                   rdValid,
  output logic                                   rdData,
  input  wire logic                              standbyReq,
  output logic                                   supplyOk,
  output logic                                   inStandby,
  output srhc_pkg::srhc_pins_t                   pins,
  input  wire logic                              memDataOut
);
  typedef struct packed {
    srhc_pkg::srhc_state_t          state;
    srhc_pkg::srhc_pins_t           pins;
    logic [srhc_pkg::CNT_WIDTH-1:0] phase;
    logic [srhc_pkg::CNT_WIDTH-1:0] cycle;
    logic                           rdValid;
    logic                           rdData;
    logic                           supplyOk;
  } srhc_host_t;

  localparam logic [srhc_pkg::CNT_WIDTH-1:0] AW_C    = srhc_pkg::CNT_WIDTH'(srhc_pkg::AW_CYCLES);
  localparam logic [srhc_pkg::CNT_WIDTH-1:0] CW_C    = srhc_pkg::CNT_WIDTH'(srhc_pkg::CW_CYCLES);
  localparam logic [srhc_pkg::CNT_WIDTH-1:0] WR_C    = srhc_pkg::CNT_WIDTH'(srhc_pkg::WR_CYCLES);
  localparam logic [srhc_pkg::CNT_WIDTH-1:0] ACC_C   = srhc_pkg::CNT_WIDTH'(srhc_pkg::ACC_CYCLES);
  localparam logic [srhc_pkg::CNT_WIDTH-1:0] CYC_C   = srhc_pkg::CNT_WIDTH'(srhc_pkg::CYC_CYCLES);
  localparam logic [srhc_pkg::CNT_WIDTH-1:0] LEAD_C  = srhc_pkg::CNT_WIDTH'(srhc_pkg::LEAD_CYCLES);
  localparam logic [srhc_pkg::CNT_WIDTH-1:0] TRAIL_C = srhc_pkg::CNT_WIDTH'(srhc_pkg::TRAIL_CYCLES);
  localparam logic [srhc_pkg::CNT_WIDTH-1:0] ONE_C   = 8'h01;

  srhc_host_t h_q;
  srhc_host_t h_d;
  logic       dataSync;

  // Memory output passes four flip-flops (three stages and the level register) before it is sampled.
  srhc_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pinIn (memDataOut),
    .level (dataSync)
  );

  // Request is taken only in idle with the cycle spacing done and no standby pending.
  assign reqReady = (h_q.state == srhc_pkg::ST_IDLE) && (h_q.cycle == '0) && !standbyReq;

  // Sequencer for write, read, spacing and standby.
  always_comb begin
    h_d         = h_q;
    h_d.rdValid = 1'b0;
    if (h_q.phase != '0) begin
      h_d.phase = h_q.phase - ONE_C;
    end
    if (h_q.cycle != '0) begin
      h_d.cycle = h_q.cycle - ONE_C;
    end
    unique case (h_q.state)
      srhc_pkg::ST_IDLE: begin
        h_d.pins.selectN    = 1'b1;
        h_d.pins.readWriteN = 1'b1;
        if (standbyReq && h_q.cycle == '0) begin
          h_d.state = srhc_pkg::ST_SLEEP;
          h_d.phase = LEAD_C;
        end else if (reqValid && reqReady) begin
          h_d.pins.wordAddress = req.addr;
          h_d.pins.dataIn      = req.data;
          h_d.pins.selectN     = 1'b0;
          h_d.cycle            = CYC_C - ONE_C;
          if (req.write) begin
            h_d.state = srhc_pkg::ST_SETUP;
            h_d.phase = AW_C;
          end else begin
            h_d.state = srhc_pkg::ST_READ;
            h_d.phase = ACC_C;
          end
        end
      end
      srhc_pkg::ST_SETUP: begin
        if (h_q.phase == ONE_C) begin
          h_d.pins.readWriteN = 1'b0;
          h_d.state           = srhc_pkg::ST_PULSE;
          h_d.phase           = CW_C - AW_C;
        end
      end
      srhc_pkg::ST_PULSE: begin
        if (h_q.phase <= ONE_C) begin
          h_d.pins.readWriteN = 1'b1;
          h_d.state           = srhc_pkg::ST_RECOV;
          h_d.phase           = WR_C;
        end
      end
      srhc_pkg::ST_RECOV: begin
        if (h_q.phase == ONE_C) begin
          h_d.pins.selectN = 1'b1;
          h_d.state        = srhc_pkg::ST_SPACE;
        end
      end
      srhc_pkg::ST_READ: begin
        if (h_q.phase == ONE_C) begin
          h_d.rdValid      = 1'b1;
          h_d.rdData       = dataSync;
          h_d.pins.selectN = 1'b1;
          h_d.state        = srhc_pkg::ST_SPACE;
        end
      end
      srhc_pkg::ST_SPACE: begin
        if (h_q.cycle <= ONE_C) begin
          h_d.state = srhc_pkg::ST_IDLE;
        end
      end
      srhc_pkg::ST_SLEEP: begin
        h_d.pins.selectN = 1'b1;
        if (h_q.supplyOk && standbyReq && h_q.phase == ONE_C) begin
          h_d.supplyOk = 1'b0;
        end else if (!h_q.supplyOk && !standbyReq && h_q.phase == '0) begin
          h_d.supplyOk = 1'b1;
          h_d.phase    = TRAIL_C;
        end else if (h_q.supplyOk && h_q.phase == '0) begin
          h_d.state = srhc_pkg::ST_IDLE;
        end
      end
      default: begin
        h_d.state = srhc_pkg::ST_IDLE;
      end
    endcase
  end

  // Register the state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      h_q                  <= '0;
      h_q.state            <= srhc_pkg::ST_IDLE;
      h_q.pins.selectN     <= 1'b1;
      h_q.pins.readWriteN  <= 1'b1;
      h_q.supplyOk         <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign pins      = h_q.pins;
  assign rdValid   = h_q.rdValid;
  assign rdData    = h_q.rdData;
  assign supplyOk  = h_q.supplyOk;
  assign inStandby = (h_q.state == srhc_pkg::ST_SLEEP);

  // Cycle counts that the checks below look back or forward over; a read answers one edge after its 80-cycle access.
  localparam int AW_N  = 20;
  localparam int WR_N  = 10;
  localparam int CYC_N = 81;

  sequence s_wrLow;
    $fell(h_q.pins.readWriteN);
  endsequence

  property p_addrBeforeWrite;
    @(posedge clk) disable iff (!rst_n) s_wrLow |-> $stable(h_q.pins.wordAddress)[*1] ##0 !h_q.pins.selectN;
  endproperty
  a_addrBeforeWrite: assert property (p_addrBeforeWrite) else $error("Write began without address set-up.");

  property p_addrSetupTime;
    @(posedge clk) disable iff (!rst_n) $fell(h_q.pins.selectN) && h_q.state == srhc_pkg::ST_SETUP |->
      h_q.pins.readWriteN [*8] ##0 $stable(h_q.pins.wordAddress);
  endproperty
  a_addrSetupTime: assert property (p_addrSetupTime) else $error("Read/write fell too soon after address.");

  property p_selectHeldToEnd;
    @(posedge clk) disable iff (!rst_n) $rose(h_q.pins.readWriteN) && h_q.state == srhc_pkg::ST_RECOV |->
      $past(h_q.pins.selectN, 1) == 1'b0;
  endproperty
  a_selectHeldToEnd: assert property (p_selectHeldToEnd) else $error("Select dropped before write end.");

  property p_recovery;
    @(posedge clk) disable iff (!rst_n) $rose(h_q.pins.readWriteN) && h_q.state == srhc_pkg::ST_RECOV |->
      !h_q.pins.selectN [*8];
  endproperty
  a_recovery: assert property (p_recovery) else $error("Select released too soon after write.");

  property p_cycleSpacing;
    @(posedge clk) disable iff (!rst_n) $fell(h_q.pins.selectN) |=> !reqReady [*8];
  endproperty
  a_cycleSpacing: assert property (p_cycleSpacing) else $error("Cycles spaced too closely.");

  property p_readFinishes;
    @(posedge clk) disable iff (!rst_n) (reqValid && reqReady && !req.write) |-> ##[1:CYC_N] rdValid;
  endproperty
  a_readFinishes: assert property (p_readFinishes) else $error("Read gave no data.");

  property p_standbyLead;
    @(posedge clk) disable iff (!rst_n) $fell(supplyOk) |-> $past(h_q.pins.selectN, 8) && h_q.pins.selectN;
  endproperty
  a_standbyLead: assert property (p_standbyLead) else $error("Supply dropped without select lead.");

  property p_standbyTrail;
    @(posedge clk) disable iff (!rst_n) $rose(supplyOk) |-> h_q.pins.selectN [*8];
  endproperty
  a_standbyTrail: assert property (p_standbyTrail) else $error("Select went active too soon after supply.");

  // Ages of the pins at the write and recovery edges, counted back from the event.
  sequence s_selRise;
    $rose(h_q.pins.selectN);
  endsequence

  property p_addrAge;
    @(posedge clk) disable iff (!rst_n) s_wrLow |-> $past(h_q.pins.selectN, AW_N) == 1'b0;
  endproperty
  a_addrAge: assert property (p_addrAge) else $error("Write began inside the address gap.");

  property p_recoveryAge;
    @(posedge clk) disable iff (!rst_n) s_selRise |-> $past(h_q.pins.readWriteN, WR_N);
  endproperty
  a_recoveryAge: assert property (p_recoveryAge) else $error("Select released within the recovery gap.");

  property p_standbySelectHigh;
    @(posedge clk) disable iff (!rst_n) inStandby |-> h_q.pins.selectN;
  endproperty
  a_standbySelectHigh: assert property (p_standbySelectHigh) else $error("Memory selected during standby.");
endmodule

// ### testbench/srhc_mem_model.sv
// Behavioural model of the 1K x 1 static memory with monitors on host pin timing.
`timescale 1ns/100ps
module srhc_mem_model (
  input  wire srhc_pkg::srhc_pins_t pins,
  input  wire logic                 supplyOk,
  output logic                      memDataOut,
  output int                        violations
);
  logic    store [1024];
  logic    junk;
  realtime tAddr, tSel, tWrEnd, tSelHigh, tSupply;

  // Start with no pin history.
  initial begin
    violations = 0;
    junk = 1'h0;
    tSel = -1000.0;
    tWrEnd = -1000.0;
    tSupply = -1000.0;
    tAddr = 0.0;
    tSelHigh = 0.0;
  end

  // A released output wanders, so a read of a floating line sees changing values.
  always #3 junk = ~junk;

  // Output path; it needs no clock and no refresh.
  always @* begin
    if (pins.selectN !== 1'h0) memDataOut = junk;
    else if (!pins.readWriteN) memDataOut = pins.dataIn;
    else memDataOut = store[pins.wordAddress];
  end

  // Only a selected write with the supply present changes a stored bit.
  always @* if (!pins.selectN && !pins.readWriteN && supplyOk) store[pins.wordAddress] = pins.dataIn;

  // Timing monitors count each short interval between host pin edges that the six host timing rules bound.
  always @(pins.wordAddress) tAddr = $realtime;
  always @(negedge pins.readWriteN) if (!pins.selectN && $realtime - tAddr < 100) violations++;
  always @(posedge pins.readWriteN) begin
    if (!pins.selectN && $realtime - tSel < 200) violations++;
    if (!pins.selectN) tWrEnd = $realtime;
  end
  always @(posedge pins.selectN) begin
    if ($realtime - tWrEnd < 50) violations++;
    tSelHigh = $realtime;
  end
  always @(negedge pins.selectN) begin
    if ($realtime - tSel < 400 || $realtime - tSupply < 100 || !supplyOk) violations++;
    tSel = $realtime;
  end
  always @(negedge supplyOk) begin
    if (!pins.selectN || $realtime - tSelHigh < 100) violations++;
    @(posedge supplyOk) tSupply = $realtime;
  end
endmodule

// ### testbench/srhc_tb.sv
// Self-checking bench for the static memory host controller.
`timescale 1ns/100ps
module tb;
  logic                 clk = 1'h0;
  logic                 rst_n, reqValid, standbyReq;
  logic                 reqReady, rdValid, rdData, supplyOk, inStandby, memDataOut;
  srhc_pkg::srhc_req_t  req;
  srhc_pkg::srhc_pins_t pins;
  int                   violations;
  int                   n_fail = 0;
  int                   checks = 0;
  int                   cycles = 0;
  logic [9:0]           addrTab [5] = '{10'h000, 10'h001, 10'h3FF, 10'h155, 10'h2AA};
  logic                 bitTab [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};

  // Controller under test and the memory it drives.
  srhc_host srhc_host_inst (.clk, .rst_n, .reqValid, .reqReady, .req, .rdValid, .rdData,
    .standbyReq, .supplyOk, .inStandby, .pins, .memDataOut);
  srhc_mem_model srhc_mem_model_inst (.pins, .supplyOk, .memDataOut, .violations);

  // Clock of 5 ns and a watchdog that cuts a hung run short.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      conclude();
    end
  end

  // Compares a bit or a count and reports a mismatch.
  task automatic chk(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic chkN(input int got, input int exp, input string what);
    chk(got == exp, 1'h1, what);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Holds a request until the controller takes it, then releases it.
  task automatic issue(input logic wr, input logic [9:0] a, input logic d);
    int n;
    n = 0;
    @(negedge clk);
    reqValid = 1'h1;
    req = '{write: wr, addr: a, data: d};
    while (reqReady !== 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(reqReady, 1'h1, "request never taken");
    @(negedge clk);
    reqValid = 1'h0;
    chk(reqReady, 1'h0, "ready during spacing");
  endtask

  // Writes one bit and checks the pins during the write pulse.
  task automatic writeBit(input logic [9:0] a, input logic d);
    int n;
    n = 0;
    issue(1'h1, a, d);
    while (pins.readWriteN !== 1'h0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(pins.readWriteN, 1'h0, "no write pulse");
    chk(pins.selectN, 1'h0, "unselected write");
    chk(pins.wordAddress === a, 1'h1, "write address");
    chk(pins.dataIn, d, "write data");
  endtask

  // Reads one bit and checks the one-cycle answer.
  task automatic readBit(input logic [9:0] a, input logic exp);
    int n;
    n = 0;
    issue(1'h0, a, 1'h0);
    while (rdValid !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(rdValid, 1'h1, "no read answer");
    chk(rdData, exp, "read data");
    @(negedge clk);
    chk(rdValid, 1'h0, "answer too long");
  endtask

  // Pins stay idle during reset.
  task automatic testReset();
    chk(pins.selectN, 1'h1, "selected in reset");
    chk(pins.readWriteN, 1'h1, "write in reset");
    chk(supplyOk, 1'h1, "supply low in reset");
    chk(rdValid, 1'h0, "answer in reset");
    $display("reset test done");
  endtask

  // Back-to-back writes at edge addresses, reads in reverse, overwrite and repeated reads.
  task automatic testWriteRead();
    for (int i = 0; i < 5; i++) writeBit(addrTab[i], bitTab[i]);
    for (int i = 4; i >= 0; i--) readBit(addrTab[i], bitTab[i]);
    writeBit(10'h155, 1'h1);
    readBit(10'h155, 1'h1);
    readBit(10'h155, 1'h1);
    readBit(10'h001, 1'h0);
    $display("write and read test done");
  endtask

  // Standby entry refuses requests and keeps the data across the low supply.
  task automatic testStandby();
    int n;
    n = 0;
    @(negedge clk);
    standbyReq = 1'h1;
    #1;
    chk(reqReady, 1'h0, "ready with standby asked");
    while (supplyOk !== 1'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(supplyOk, 1'h0, "supply never released");
    chk(pins.selectN, 1'h1, "selected in standby");
    chk(inStandby, 1'h1, "standby flag");
    chk(reqReady, 1'h0, "ready in standby");
    repeat (40) @(negedge clk);
    standbyReq = 1'h0;
    n = 0;
    while (inStandby !== 1'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(supplyOk, 1'h1, "supply not restored");
    chk(inStandby, 1'h0, "standby never left");
    readBit(10'h3FF, 1'h1);
    $display("standby test done");
  endtask

  // Main sequence: reset for six cycles, then the tests.
  initial begin
    rst_n = 1'h0;
    reqValid = 1'h0;
    standbyReq = 1'h0;
    req = '0;
    repeat (6) @(negedge clk);
    testReset();
    rst_n = 1'h1;
    testWriteRead();
    testStandby();
    chkN(violations, 0, "pin timing broken");
    conclude();
  end
endmodule
